/* bench/tb_top.sv */
// Testbench: flag interlock block driven over APB and the command port
`timescale 1ns/1ps
module tb_top;
   import xfi_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic         clk_sys     = 1'b0;
   logic         resetn      = 1'b1;
   xfi_apb_req_t req         = '0;
   xfi_apb_rsp_t rsp;
   xfi_cmd_t     cmd         = '0;
   xfi_done_t    done;
   logic [1:0]   pin_o;
   logic [1:0]   pin_oe;
   logic [1:0]   pin_lvl;
   logic         hold_req    = 1'b1;
   logic         hold_ack;
   logic [2:0]   waits;
   logic [7:0]   async_en;
   logic [7:0]   busy_cyc    = 8'h00;
   logic         one_val;
   logic [31:0]  rd;
   logic         err;
   int           error_cnt   = 0;
   int           check_count = 0;
   int           tick        = 0;

   always #5 clk_sys = ~clk_sys;
   // A released flag zero pin sits high through its pull-up; a released flag one follows the partner
   assign pin_lvl[0] = pin_oe[0] ? pin_o[0] : 1'b1;
   assign pin_lvl[1] = pin_oe[1] ? pin_o[1] : one_val;

   xfi_flag_interlock xfi_flag_interlock_inst (
      .clk_sys(clk_sys), .resetn(resetn), .apb_req(req), .apb_rsp(rsp), .cmd(cmd), .done(done),
      .flag_pin_i(pin_lvl), .flag_pin_o(pin_o), .flag_pin_oe(pin_oe), .hold_req(hold_req),
      .hold_acknowledge(hold_ack), .bus_wait_states(waits), .async_pin_enable(async_en));
   xfi_partner xfi_partner_inst (
      .clk_sys(clk_sys), .zero_lvl(pin_lvl[0]), .busy_cyc(busy_cyc), .one_val(one_val));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      do @(posedge clk_sys); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask

   // Holds the command until done; conflict is dropped after stall cycles
   task automatic cmd_run(input xfi_op_t op, input int stall, input logic [23:0] a,
                          output int cyc, output logic saw_low);
      cyc = 0;
      saw_low = 1'b0;
      @(posedge clk_sys);
      cmd <= '{valid: 1'b1, op: op, conflict: (stall > 0), addr: a};
      do begin
         @(posedge clk_sys);
         cyc++;
         if (pin_o[0] === 1'b0) saw_low = 1'b1;
         if (cyc <= stall) chk(done.store_addr_valid, 1'b0, "address during stall");
         if (done.store_addr_valid === 1'b1) chk(done.store_addr, a, "store address");
         if (cyc == stall) cmd.conflict <= 1'b0;
      end while (done.cmd_done !== 1'b1);
      cmd <= '0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      int n;
      n = 0;
      repeat (24) begin
         @(posedge clk_sys);
         if (hold_ack !== 1'b1) n++;
      end
      chk(n <= HOLD_GRANT_MAX, 1'b1, "hold grant late");
      chk(pin_oe, 2'b00, "flag drivers in reset");
      chk(async_en, 8'h00, "async pins in reset");
      chk(waits, WAIT_RESET, "wait states in reset");
      resetn <= 1'b1;
      hold_req <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask

   task automatic t_regs();
      chk(async_en, ASYNC_ON, "async pins after reset");
      apb(1'b0, BUS_CTRL_OFS, 32'h0);
      chk(rd[2:0], WAIT_RESET, "wait field");
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[STAT_HOLD_POS], 1'b0, "hold released");
      apb(1'b0, 8'h0C, 32'h0);
      chk(err, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped read");
      apb(1'b1, FLAG_CTRL_OFS, (32'h1 << DIR0_POS) | (32'h1 << OUT0_POS));
      repeat (4) @(posedge clk_sys);
      chk(pin_oe, 2'b01, "direction");
      chk(pin_o[0], 1'b1, "output high");
      apb(1'b0, FLAG_CTRL_OFS, 32'h0);
      chk(rd[IN1_POS], 1'b1, "flag one input");
      apb(1'b1, FLAG_CTRL_OFS, 32'h1 << DIR0_POS);
      repeat (4) @(posedge clk_sys);
      chk(pin_o[0], 1'b0, "output low");
      apb(1'b1, FLAG_CTRL_OFS, 32'h0);
      repeat (4) @(posedge clk_sys);
      chk(pin_oe[0], 1'b0, "released");
      repeat (8) @(posedge clk_sys);
      apb(1'b0, FLAG_CTRL_OFS, 32'h0);
      chk(rd[IN0_POS], 1'b1, "captured level");
      apb(1'b1, BUS_CTRL_OFS, 32'h0);
      apb(1'b0, BUS_CTRL_OFS, 32'h0);
      chk(rd[2:0], 3'h0, "wait field written");
      apb(1'b1, FLAG_CTRL_OFS, 32'h1 << DIR0_POS);
   endtask

   task automatic t_interlock();
      int   c;
      logic lo;
      cmd_run(XFI_OP_STORE, 10, 24'hABCDE1, c, lo);
      repeat (2) @(posedge clk_sys);
      chk(pin_o[0], 1'b1, "store raises zero");
      busy_cyc <= 8'h0C;
      cmd_run(XFI_OP_SIGNAL, 0, 24'h0, c, lo);
      chk({c >= 12, lo}, 2'b11, "signal waits low");
      repeat (2) @(posedge clk_sys);
      chk(pin_o[0], 1'b1, "signal raises zero");
      cmd_run(XFI_OP_LOAD, 0, 24'h0, c, lo);
      chk(c >= 12, 1'b1, "load waits for flag one");
      repeat (2) @(posedge clk_sys);
      chk(pin_o[0], 1'b0, "load keeps zero low");
      cmd_run(XFI_OP_STORE, 0, 24'h12345F, c, lo);
      chk(c <= 4, 1'b1, "store without conflict");
   endtask

   task automatic t_async();
      @(posedge clk_sys);
      resetn <= 1'b0;
      hold_req <= 1'b1;
      #1;
      chk(pin_oe, 2'b00, "async release");
      chk(async_en, 8'h00, "async pins");
      t_reset();
   endtask

   // ------------------------------------------------------------
   // Sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      tick <= tick + 1;
      if (tick == 6000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      // Falling at time zero lets the pin drivers clear before the first edge
      resetn <= 1'b0;
      t_reset();
      t_regs();
      t_interlock();
      t_async();
      test_done();
   end
endmodule // tb_top

/* bench/xfi_partner.sv */
// Partner model: the other processor answering on flag one
`timescale 1ns/1ps
module xfi_partner (
   // Clock
   input  wire logic       clk_sys,
   // Flag lines and busy length
   input  wire logic       zero_lvl,
   input  wire logic [7:0] busy_cyc,
   output logic            one_val
);
   logic [7:0] cnt_reg;

   // ------------------------------------------------------------
   // Busy answer
   // ------------------------------------------------------------
   // Stays busy while flag zero is high and busy_cyc cycles after it falls
   always_ff @(posedge clk_sys) begin
      if (zero_lvl) begin
         cnt_reg <= busy_cyc;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end

   // Moves only after a clock edge, so the level holds across the phase-one sample
   assign one_val = zero_lvl | (cnt_reg != 8'h00);
endmodule // xfi_partner

/* hdl/xfi_flag_interlock.sv */
// Flag pins, interlock handshake, bus hold grant and reset handling with APB registers
//
// How it works
// - Interlocked load lowers flag zero at phase three, samples flag one at phase one.
// - Signal interlock lowers then raises flag zero, sampling flag one between.
// - Interlocked store raises flag zero at the start of execute.
// - Store address goes out at execute, held off while a conflict stalls it.
// - Output pins follow output-value bits 2 and 6 after phase three.
// - Direction bits 1 and 5 choose input or output per flag pin.
// - Sampled input levels appear in bits 3 and 7.
// - Output to input: release at phase three, capture at next phase one; the code reads the new level first at the third phase one.
// - Input to output: start driving at phase three.
// - Reset taken at any time; internal reset begins up to four clock cycles after the pin.
// - Reset releases flag, serial and timer pins without waiting for a clock.
// - Reset sets the bus wait-state field to seven.
// - Hold request during reset is granted within nine phase cycles.
// - Reset puts both flag pins and other async pins in high impedance.
`timescale 1ns/1ps
module xfi_flag_interlock (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   // APB slave
   input  xfi_pkg::xfi_apb_req_t      apb_req,
   output xfi_pkg::xfi_apb_rsp_t      apb_rsp,
   // Interlock commands from the core
   input  xfi_pkg::xfi_cmd_t          cmd,
   output xfi_pkg::xfi_done_t         done,
   // Flag pins
   input  wire logic [1:0]            flag_pin_i,
   output logic      [1:0]            flag_pin_o,
   output logic      [1:0]            flag_pin_oe,
   // Bus hold and bus control
   input  wire logic                  hold_req,
   output logic                       hold_acknowledge,
   output logic      [2:0]            bus_wait_states,
   // Enable for serial and timer pin drivers
   output logic      [7:0]            async_pin_enable
);
   import xfi_pkg::*;

   // ------------------------------------------------------------
   // Synchronisers and phase strobes
   // ------------------------------------------------------------
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_in;
   logic [1:0]        flag_s;
   logic              hold_s;
   logic              rstn_s;
   logic              rst_int;
   logic              h3;
   logic              h1;

   assign raw_in  = {resetn, hold_req, flag_pin_i};
   assign flag_s  = sync_in[1:0];
   assign hold_s  = sync_in[2];
   assign rstn_s  = sync_in[3];
   // Filtered reset trails the pin by up to four cycles
   assign rst_int = !rstn_s;

   xfi_pin_sync u_sync (
      .clk_sys (clk_sys),
      .raw_i   (raw_in),
      .sync_o  (sync_in)
   );

   xfi_phase_gen u_phase (
      .clk_sys          (clk_sys),
      .rst              (rst_int),
      .phase_three_rise (h3),
      .phase_one_fall   (h1)
   );

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   logic wr_en;
   logic wr_flag;
   logic wr_bus;

   assign wr_en   = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
   assign wr_flag = wr_en && (apb_req.paddr == FLAG_CTRL_OFS);
   assign wr_bus  = wr_en && (apb_req.paddr == BUS_CTRL_OFS);

   // ------------------------------------------------------------
   // Interlock sequencer
   // ------------------------------------------------------------
   xfi_state_t state_reg;
   xfi_state_t state_next;
   logic       lower0;
   logic       raise0;
   logic       fin;
   logic       addr_go;
   logic       accept;

   assign accept = h3 && cmd.valid && !done.cmd_done;

   always_comb begin
      state_next = state_reg;
      lower0     = 1'b0;
      raise0     = 1'b0;
      fin        = 1'b0;
      addr_go    = 1'b0;
      case (state_reg)
         XFI_IDLE: begin
            if (accept) begin
               case (cmd.op)
                  XFI_OP_LOAD: begin
                     lower0     = 1'b1;
                     state_next = XFI_LOAD_WAIT;
                  end
                  XFI_OP_SIGNAL: begin
                     lower0     = 1'b1;
                     state_next = XFI_SIG_WAIT;
                  end
                  XFI_OP_STORE: begin
                     raise0 = 1'b1;
                     if (!cmd.conflict) begin
                        addr_go = 1'b1;
                        fin     = 1'b1;
                     end else begin
                        state_next = XFI_STORE_WAIT;
                     end
                  end
                  default: begin
                     fin = 1'b1;
                  end
               endcase
            end
         end
         XFI_LOAD_WAIT: begin
            // Load completes only once the partner shows flag one low
            if (h1 && !flag_s[1]) begin
               fin        = 1'b1;
               state_next = XFI_IDLE;
            end
         end
         XFI_SIG_WAIT: begin
            if (h1 && !flag_s[1]) begin
               state_next = XFI_SIG_RAISE;
            end
         end
         XFI_SIG_RAISE: begin
            if (h3) begin
               raise0     = 1'b1;
               fin        = 1'b1;
               state_next = XFI_IDLE;
            end
         end
         XFI_STORE_WAIT: begin
            if (h3 && !cmd.conflict) begin
               addr_go    = 1'b1;
               fin        = 1'b1;
               state_next = XFI_IDLE;
            end
         end
         default: begin
            state_next = XFI_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst_int) begin
         state_reg <= XFI_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst_int) begin
         done <= '0;
      end else begin
         done.cmd_done         <= fin;
         done.store_addr_valid <= addr_go;
         if (addr_go) begin
            done.store_addr <= cmd.addr;
         end
      end
   end

   // ------------------------------------------------------------
   // Flag control register
   // ------------------------------------------------------------
   logic [1:0] dir_reg;
   logic [1:0] out_reg;
   logic [1:0] in_reg;
   logic [1:0] dir_next;
   logic [1:0] out_next;

   // Sequencer wins over a software write in the same cycle
   always_comb begin
      dir_next = dir_reg;
      out_next = out_reg;
      for (int i = 0; i < 2; i++) begin
         if (wr_flag) begin
            dir_next[i] = apb_req.pwdata[dir_pos(i)];
            out_next[i] = apb_req.pwdata[out_pos(i)];
         end
      end
      if (lower0) begin
         out_next[0] = 1'b0;
      end
      if (raise0) begin
         out_next[0] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst_int) begin
         dir_reg <= DIR_RESET;
         out_reg <= OUT_RESET;
      end else begin
         dir_reg <= dir_next;
         out_reg <= out_next;
      end
   end

   // Pins only change at phase three, so direction and value move together.
   // Async clear keeps the pins released while the clock may not be running.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flag_pin_oe <= DIR_RESET;
         flag_pin_o  <= OUT_RESET;
      end else if (rst_int) begin
         flag_pin_oe <= DIR_RESET;
         flag_pin_o  <= OUT_RESET;
      end else if (h3) begin
         flag_pin_oe <= dir_next;
         flag_pin_o  <= out_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         async_pin_enable <= ASYNC_OFF;
      end else if (rst_int) begin
         async_pin_enable <= ASYNC_OFF;
      end else begin
         async_pin_enable <= ASYNC_ON;
      end
   end

   // Capture only while undriven; flag_s lags, so the first two phase-one captures after release still read the pre-release level
   always_ff @(posedge clk_sys) begin
      if (rst_int) begin
         in_reg <= IN_RESET;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (h1 && !flag_pin_oe[i]) begin
               in_reg[i] <= flag_s[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Bus control and hold
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst_int) begin
         bus_wait_states <= WAIT_RESET;
      end else if (wr_bus) begin
         bus_wait_states <= apb_req.pwdata[WAIT_LSB +: 3];
      end
   end

   // Hold logic follows the request every cycle during reset, so a request made during reset is granted
   always_ff @(posedge clk_sys) begin
      if (h3 || rst_int) begin
         hold_acknowledge <= hold_s;
      end
   end

   // ------------------------------------------------------------
   // APB response
   // ------------------------------------------------------------
   logic [31:0] flag_view;
   logic [31:0] rd_mux;
   logic        addr_ok;

   always_comb begin
      flag_view = 32'h0;
      for (int i = 0; i < 2; i++) begin
         flag_view[dir_pos(i)] = dir_reg[i];
         flag_view[out_pos(i)] = out_reg[i];
         flag_view[in_pos(i)]  = in_reg[i];
      end
   end

   always_comb begin
      rd_mux  = 32'h0;
      addr_ok = 1'b1;
      case (apb_req.paddr)
         FLAG_CTRL_OFS: rd_mux = flag_view;
         BUS_CTRL_OFS:  rd_mux[WAIT_LSB +: 3] = bus_wait_states;
         STATUS_OFS: begin
            rd_mux[2:0]           = state_reg;
            rd_mux[STAT_HOLD_POS] = hold_acknowledge;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // Answer is registered from the setup cycle: zero wait states
   always_ff @(posedge clk_sys) begin
      if (rst_int) begin
         apb_rsp <= '0;
      end else if (apb_req.psel && !apb_req.penable) begin
         apb_rsp.pready  <= 1'b1;
         apb_rsp.pslverr <= !addr_ok;
         apb_rsp.prdata  <= apb_req.pwrite ? 32'h0 : rd_mux;
      end else begin
         apb_rsp <= '0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   localparam int HOLD_BOUND = HOLD_GRANT_MAX;

   default clocking cb @(posedge clk_sys);
   endclocking
   // The pin drivers clear at once on the pin, before the synchronised reset arrives
   default disable iff (rst_int || !resetn);

   sequence load_start_s;
      state_reg == XFI_IDLE && accept && cmd.op == XFI_OP_LOAD;
   endsequence

   sequence sig_start_s;
      state_reg == XFI_IDLE && accept && cmd.op == XFI_OP_SIGNAL;
   endsequence

   sequence store_start_s;
      state_reg == XFI_IDLE && accept && cmd.op == XFI_OP_STORE;
   endsequence

   sequence sig_raise_s;
      state_reg == XFI_SIG_RAISE && h3;
   endsequence

   load_lower_a: assert property (load_start_s |=> !flag_pin_o[0] && state_reg == XFI_LOAD_WAIT)
      else $error("load did not lower flag zero");

   load_block_a: assert property (state_reg == XFI_LOAD_WAIT && h1 && flag_s[1]
                                  |=> state_reg == XFI_LOAD_WAIT && !done.cmd_done)
      else $error("load finished with flag one high");

   sig_lower_a: assert property (sig_start_s |=> !out_reg[0] && state_reg == XFI_SIG_WAIT)
      else $error("signal interlock did not lower flag zero");

   sig_raise_a: assert property (sig_raise_s |=> out_reg[0] && done.cmd_done && state_reg == XFI_IDLE)
      else $error("signal interlock did not raise flag zero");

   store_raise_a: assert property (store_start_s |=> flag_pin_o[0] && out_reg[0])
      else $error("store did not raise flag zero");

   store_addr_a: assert property (store_start_s ##0 !cmd.conflict
                                  |=> done.store_addr_valid && done.store_addr == $past(cmd.addr))
      else $error("store address not issued at execute");

   store_hold_a: assert property (state_reg == XFI_STORE_WAIT && cmd.conflict |=> !done.store_addr_valid)
      else $error("store address issued during conflict");

   out_follow_a: assert property (h3 |=> flag_pin_o == out_reg && flag_pin_oe == dir_reg)
      else $error("flag pins do not follow control register");

   pin_steady_a: assert property (!h3 |=> $stable(flag_pin_oe) && $stable(flag_pin_o))
      else $error("flag pin changed outside phase three");

   in_capture_a: assert property (h1 && !flag_pin_oe[1] |=> in_reg[1] == $past(flag_s[1]))
      else $error("input level not captured at phase one");

   wait_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0)
                                  rst_int |=> bus_wait_states == WAIT_RESET)
      else $error("wait states not seven after reset");

   hold_grant_a: assert property (@(posedge clk_sys) disable iff (1'b0)
                                  $rose(hold_req) ##0 hold_req [*8]
                                  |-> ##[1:HOLD_BOUND] hold_acknowledge)
      else $error("hold not granted in time");

   pin_release_a: assert property (@(posedge clk_sys) disable iff (1'b0)
                                   !resetn |-> flag_pin_oe == 2'h0 && async_pin_enable == ASYNC_OFF)
      else $error("pins driven during reset");

endmodule // xfi_flag_interlock

/* hdl/xfi_phase_gen.sv */
// Phase enable generator: one-cycle strobes for phase three rise and phase one fall
`timescale 1ns/1ps
module xfi_phase_gen (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Phase strobes
   output logic      phase_three_rise,
   output logic      phase_one_fall
);
   import xfi_pkg::*;

   logic [3:0] cnt_reg;

   always_ff @(posedge clk_sys) begin
      if (rst || cnt_reg == 4'(PHASE_DIV - 1)) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

   // Strobes sit half a phase period apart
   always_ff @(posedge clk_sys) begin
      phase_three_rise <= !rst && (cnt_reg == 4'h0);
      phase_one_fall   <= !rst && (cnt_reg == 4'(PHASE_DIV / 2));
   end

endmodule // xfi_phase_gen

/* hdl/xfi_pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module xfi_pin_sync (
   // Clock
   input  wire logic                       clk_sys,
   // Raw and filtered levels
   input  wire logic [xfi_pkg::SYNC_W-1:0] raw_i,
   output logic      [xfi_pkg::SYNC_W-1:0] sync_o
);
   import xfi_pkg::*;

   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         always_ff @(posedge clk_sys) begin
            s1_reg <= raw_i[g];
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
         end
         // A change counts only once two late stages agree
         always_ff @(posedge clk_sys) begin
            if (s2_reg == s3_reg) begin
               sync_o[g] <= s3_reg;
            end
         end
      end
   endgenerate

endmodule // xfi_pin_sync

/* hdl/xfi_pkg.sv */
// Package: constants, register map and carrier types of the flag interlock block
package xfi_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned PHASE_PERIOD_NS  = 20;
   localparam int unsigned PHASE_DIV        = PHASE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned HOLD_GRANT_H_CYC = 9;
   localparam int unsigned HOLD_GRANT_MAX   = HOLD_GRANT_H_CYC * PHASE_DIV;
   localparam int unsigned RESET_MIN_H_CYC  = 10;
   localparam int unsigned SYNC_W           = 4;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] FLAG_CTRL_OFS = 8'h00;
   localparam logic [7:0] BUS_CTRL_OFS  = 8'h04;
   localparam logic [7:0] STATUS_OFS    = 8'h08;
   localparam int         DIR0_POS      = 1;
   localparam int         OUT0_POS      = 2;
   localparam int         IN0_POS       = 3;
   localparam int         DIR1_POS      = 5;
   localparam int         OUT1_POS      = 6;
   localparam int         IN1_POS       = 7;
   localparam int         WAIT_LSB      = 0;
   localparam int         STAT_HOLD_POS = 4;
   localparam logic [2:0] WAIT_RESET    = 3'h7;
   localparam logic [1:0] DIR_RESET     = 2'h0;
   localparam logic [1:0] OUT_RESET     = 2'h0;
   localparam logic [1:0] IN_RESET      = 2'h0;
   localparam logic [7:0] ASYNC_OFF     = 8'h00;
   localparam logic [7:0] ASYNC_ON      = 8'hFF;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      XFI_OP_LOAD   = 2'h0,
      XFI_OP_STORE  = 2'h1,
      XFI_OP_SIGNAL = 2'h2
   } xfi_op_t;

   typedef enum logic [2:0] {
      XFI_IDLE       = 3'h0,
      XFI_LOAD_WAIT  = 3'h1,
      XFI_SIG_WAIT   = 3'h3,
      XFI_SIG_RAISE  = 3'h2,
      XFI_STORE_WAIT = 3'h6
   } xfi_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } xfi_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } xfi_apb_rsp_t;

   typedef struct packed {
      logic        valid;
      xfi_op_t     op;
      logic        conflict;
      logic [23:0] addr;
   } xfi_cmd_t;

   typedef struct packed {
      logic        cmd_done;
      logic        store_addr_valid;
      logic [23:0] store_addr;
   } xfi_done_t;

   function automatic int dir_pos(input int i);
      return (i == 0) ? DIR0_POS : DIR1_POS;
   endfunction

   function automatic int out_pos(input int i);
      return (i == 0) ? OUT0_POS : OUT1_POS;
   endfunction

   function automatic int in_pos(input int i);
      return (i == 0) ? IN0_POS : IN1_POS;
   endfunction

endpackage
